/* File: common/ist_cfg.svh */
// Purpose: Constants of the in-frame serial target.
// Assumes: Included by its bare name.
// Notes:   Offsets, fields, fixed values, reset values and counts only.
`ifndef IST_CFG_SVH
`define IST_CFG_SVH
// ****************************************
// Frame geometry
// ****************************************
`define IST_FRAME_BITS  32
`define IST_WORD_BITS   16
`define IST_CHIP_BITS   2
`define IST_ADDR_DONE   12
`define IST_CHECK_END   8
// ****************************************
// Instruction word fields (upper half)
// ****************************************
`define IST_POS_RW      13
`define IST_POS_CM      12
`define IST_POS_AH      11
`define IST_POS_AL      4
// ****************************************
// Fixed values and reset values
// ****************************************
`define IST_CHIP_MSB    1'b1
`define IST_CHK_PAT     5'h15
`define IST_UNUSED_WORD 16'hffff
`define IST_CFG_RST     1'b1
`define IST_CS_RST      1'b1
`define IST_SYNC_LAT    3'h4
`endif

/* File: common/ist_pkg.sv */
// Purpose: Types of the in-frame serial target.
// Assumes: Used by scoped names only.
// Notes:   Constants live in ist_cfg.svh.
package ist_pkg;
  // Register address of the device register file
  typedef logic [7:0] ist_addr_t;
  // Phase of the serial frame seen on a rising clock edge
  typedef enum {
    PH_CHIP,
    PH_CHECK,
    PH_ECHO,
    PH_DATA
  } ist_phase_e;
endpackage

/* File: common/ist_tgl_if.sv */
// Purpose: Toggle event carried between two clock domains.
// Assumes: Source toggles at most once per few sink cycles.
// Notes:   Data beside the toggle is held stable by the source.
`timescale 1ns/1ps
interface ist_tgl_if;
  logic tgl;  // Event toggle, source domain
  logic pls;  // Event pulse, sink domain
  // Source side: flips the toggle
  modport src (output tgl, input pls);
  // Sink side: turns the toggle into a pulse
  modport snk (input tgl, output pls);
endinterface

/* File: src/ist_pin_sync.sv */
// Purpose: Three-flop input synchroniser with agreement filter.
// Assumes: Reset is synchronous, active low.
// Notes:   Output changes once stages two and three agree.
`timescale 1ns/1ps
module ist_pin_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Asynchronous inputs and filtered outputs
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // ****************************************
  // One filter per bit
  // ****************************************
  for (genvar b = 0; b < W; b++) begin : g_bit
    logic s1_r;  // First stage, read by s2 only
    logic s2_r;  // Second stage
    logic s3_r;  // Third stage
    // Shift chain and agreement update
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        s1_r     <= INIT[b];
        s2_r     <= INIT[b];
        s3_r     <= INIT[b];
        q_o[b]   <= INIT[b];
      end else begin
        s1_r <= d_i[b];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          q_o[b] <= s3_r;
        end
      end
    end
  end
endmodule // ist_pin_sync

/* File: src/ist_tgl_sync.sv */
// Purpose: Turns a toggle from another domain into a pulse.
// Assumes: Reset is synchronous, active low.
// Notes:   Pulse lasts one sink clock.
`timescale 1ns/1ps
module ist_tgl_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Toggle in, pulse out
  ist_tgl_if.snk    ev
);
  logic s1_r;  // First stage, read by s2 only
  logic s2_r;  // Second stage
  logic s3_r;  // Edge memory
  // Two-flop crossing and edge memory
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= ev.tgl;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Any change is one event
  assign ev.pls = s2_r ^ s3_r;
endmodule // ist_tgl_sync

/* File: src/ist_spi_target.sv */
// Purpose: In-frame 32-bit serial target with chip address.
// Assumes: Mode 1 serial master, sclk idle low at frame start.
// Notes:   Link logic runs on SPI_SCLK_I; registers on SYS_CLK_I.
//
// How it works
// (RL1) Reset holds link idle, MISO released
// (RL2) Chip select high forces link idle
// (RL3) Sample MOSI falling, drive MISO rising
// (RL4) Apply instruction at chip select rise
// (RL5) Foreign chip address: ignore, never drive
// (RL6) Foreign frame never sets failure flag
// (RL7) Check byte shifted during instruction half
// (RL8) Reads drop data, still check parity
// (RL9) Missing register address is invalid
// (RL10) Early chip select release is invalid
// (RL11) Either parity bit wrong is invalid
// (RL12) Invalid access changes no register; a burst write still commits each good word
// (RL13) Unused code answers all-ones word
// (RL14) Write needs exact falling edge count
// (RL15) Invalid access sets flag, shown next
// (RL16) Reset release under low select sets flag
// (RL17) Master keeps select high minimum time
// (RL18) Master keeps sclk under maximum rate
// (RL19) Address is one, then strap bit
// (RL20) Open strap pin reads as one
// (RL21) Master starts with sclk low
// (RL22) Whole request in one frame, bursts
// (RL23) Odd parity on each frame half
// (RL24) Read/write, address, data bit fields
// (RL25) Length check or per-word burst commit
// (RL26) Check byte 10101, flag, address echo
// (RL27) Release MISO while select high
`timescale 1ns/1ps
`include "ist_cfg.svh"
module ist_spi_target #(
  parameter int CNT_W = 12  // Edge counter width, saturates
) (
  // System clock and reset
  input  wire logic               SYS_CLK_I,
  input  wire logic               RESETN_I,
  // Serial link pins
  input  wire logic               SPI_SCLK_I,
  input  wire logic               SPI_CS_N_I,
  input  wire logic               SPI_MOSI_I,
  output logic                    SPI_MISO_O,
  output logic                    SPI_MISO_OE_O,
  // Address strap pin
  input  wire logic               CTRL_CFG_I,
  // Register file read port
  output ist_pkg::ist_addr_t      REG_ADDR_O,
  input  wire logic [14:0]        REG_RD_DATA_I,
  input  wire logic               REG_EXISTS_I,
  // Register file write port
  output logic                    REG_WR_O,
  output ist_pkg::ist_addr_t      REG_WADDR_O,
  output logic [14:0]             REG_WDATA_O,
  // Status
  output logic                    TRANSFER_FAIL_O,
  output logic                    CHIP_ADDR_LSB_O
);
  // ****************************************
  // Declarations
  // ****************************************
  logic               rst_ok_r;     // Registered reset release
  logic [1:0]         pin_q;        // Filtered strap and select
  logic               cs_q;         // Filtered chip select
  logic               cs_d_r;       // Select, one cycle late
  logic               cs_rise;      // End of frame event
  logic [2:0]         rel_cnt_r;    // Wait after reset release
  logic               rel_done_r;   // Strap already caught
  logic               latch_now;    // Strap catch cycle
  logic               addr_lo_r;    // Chip address low bit
  logic               fail_r;       // transfer_fail_flag
  logic               fr_seen_r;    // Last frame toggle seen
  logic               new_frame;    // Frame had clock edges
  logic               rd_pend_r;    // Read lookup in progress
  ist_pkg::ist_addr_t rd_addr_r;    // Address being looked up
  logic [14:0]        rdata_r;      // Looked-up register data
  logic               rex_r;        // Looked-up address exists
  logic               ack_tgl_r;    // Lookup done toggle
  logic               rw_bit;       // Write when set
  logic               cm_bit;       // frame_length_check
  ist_pkg::ist_addr_t i_addr;       // Instruction address
  logic               full;         // Exactly one frame long
  logic               cut_short;    // Edge count is wrong
  logic               invalid;      // Frame is an invalid access
  logic               wr_r;         // Write strobe
  ist_pkg::ist_addr_t waddr_r;      // Write address
  logic [14:0]        wdata_r;      // Write data
  // Link side
  logic               link_rst;     // Idles the link logic
  logic               l_arst;       // Clears link status
  logic               start_r;      // Next edge opens a frame
  logic [CNT_W-1:0]   cnt_r;        // Falling edges this frame
  logic [CNT_W-1:0]   cnt_nxt;      // Count after this edge
  logic [31:0]        sh_r;         // Received bits
  logic [15:0]        rx_word;      // Last 16 bits incl. this one
  logic               word_end;     // A data word just completed
  logic               fr_tgl_r;     // Flips once per frame
  logic               match_r;      // Chip address matched
  logic [15:0]        instr_r;      // Instruction half
  logic               ipar_ok_r;    // instruction_parity_bit ok
  logic               dbad_r;       // data_parity_bit wrong
  logic               rq_tgl_r;     // Lookup request toggle
  ist_pkg::ist_addr_t rq_addr_r;    // Lookup address
  logic               pw_tgl_r;     // Burst write toggle
  ist_pkg::ist_addr_t pw_addr_r;    // Burst write address
  logic [14:0]        pw_data_r;    // Burst write data
  logic               ack_s1_r;     // Lookup done, first stage
  logic               ack_s2_r;     // Lookup done, second stage
  logic               ack_ok;       // Lookup finished in time
  logic               ex_cur_r;     // Current word address ok
  logic               bad_addr_r;   // Unused code this frame
  logic [CNT_W-1:0]   k;            // Edges before this rise
  ist_pkg::ist_phase_e ph;          // Phase at this rise
  logic               load;         // Load a response word
  logic [15:0]        rsp_word;     // Response word
  logic [5:0]         chk;          // Pattern and flag
  logic [2:0]         chk_idx;      // Bit of chk to send
  logic               miso_r;       // Serial output bit
  logic               oe_r;         // Serial output enable
  logic [14:0]        tx_sh_r;      // Response shifter
  ist_tgl_if          rq_if ();     // Lookup request crossing
  ist_tgl_if          pw_if ();     // Burst write crossing

  // ****************************************
  // System domain: reset, pins, strap
  // ****************************************
  // Reset release is registered once
  always_ff @(posedge SYS_CLK_I) begin
    rst_ok_r <= RESETN_I; // RL1
  end

  // Select and strap pins pass the filter
  ist_pin_sync #(
    .W    (2),
    .INIT ({`IST_CFG_RST, `IST_CS_RST})
  ) u_pins (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESETN_I),
    .d_i     ({CTRL_CFG_I, SPI_CS_N_I}),
    .q_o     (pin_q)
  );
  assign cs_q = pin_q[0];

  // Select edge memory
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      cs_d_r <= `IST_CS_RST;
    end else begin
      cs_d_r <= cs_q;
    end
  end
  assign cs_rise = cs_q & ~cs_d_r & rel_done_r;

  // Strap caught once the filter has settled
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      rel_cnt_r  <= '0;
      rel_done_r <= 1'b0;
      addr_lo_r  <= `IST_CFG_RST; // RL20
    end else if (!rel_done_r) begin
      rel_cnt_r <= rel_cnt_r + 3'h1;
      if (latch_now) begin
        rel_done_r <= 1'b1;
        addr_lo_r  <= pin_q[1]; // RL19
      end
    end
  end
  assign latch_now = !rel_done_r && (rel_cnt_r == `IST_SYNC_LAT);
  assign CHIP_ADDR_LSB_O = addr_lo_r;

  // ****************************************
  // System domain: end-of-frame decision
  // ****************************************
  // Link status is static while select is high
  assign new_frame = fr_tgl_r != fr_seen_r; // RL17
  assign rw_bit    = instr_r[`IST_POS_RW]; // RL24
  assign cm_bit    = instr_r[`IST_POS_CM];
  assign i_addr    = instr_r[`IST_POS_AH:`IST_POS_AL];
  assign full      = cnt_r == CNT_W'(`IST_FRAME_BITS);
  // Burst needs whole words beyond the first frame
  always_comb begin
    if (cm_bit) begin
      cut_short = !full; // RL25
    end else begin
      cut_short = (cnt_r < CNT_W'(`IST_FRAME_BITS)) ||
                  (cnt_r[3:0] != 4'h0);
    end
  end
  assign invalid = !ipar_ok_r || dbad_r || bad_addr_r ||
                   cut_short; // RL9 RL10 RL11

  // Frame toggle bookkeeping
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      fr_seen_r <= 1'b0;
    end else if (cs_rise) begin
      fr_seen_r <= fr_tgl_r;
    end
  end

  // Failure flag, replaced at each own frame end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      fail_r <= 1'b0;
    end else if (latch_now && !cs_q) begin
      fail_r <= 1'b1; // RL16
    end else if (cs_rise && new_frame && match_r) begin
      fail_r <= invalid; // RL6 RL15
    end
  end
  assign TRANSFER_FAIL_O = fail_r;

  // Writes: single frame at select rise, burst per word
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      wr_r    <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
    end else if (cs_rise && new_frame && match_r &&
                 !invalid && rw_bit && cm_bit) begin
      wr_r    <= 1'b1; // RL4 RL12 RL14
      waddr_r <= i_addr;
      wdata_r <= sh_r[14:0];
    end else if (pw_if.pls) begin
      wr_r    <= 1'b1; // RL22 RL25
      waddr_r <= pw_addr_r;
      wdata_r <= pw_data_r;
    end else begin
      wr_r <= 1'b0;
    end
  end
  assign REG_WR_O    = wr_r;
  assign REG_WADDR_O = waddr_r;
  assign REG_WDATA_O = wdata_r;

  // ****************************************
  // System domain: register lookup service
  // ****************************************
  ist_tgl_sync u_rq_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESETN_I),
    .ev      (rq_if.snk)
  );
  ist_tgl_sync u_pw_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESETN_I),
    .ev      (pw_if.snk)
  );
  assign rq_if.tgl = rq_tgl_r;
  assign pw_if.tgl = pw_tgl_r;

  // Present address, take answer next cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      rd_pend_r <= 1'b0;
      rd_addr_r <= '0;
      rdata_r   <= '0;
      rex_r     <= 1'b0;
      ack_tgl_r <= 1'b0;
    end else if (rq_if.pls) begin
      rd_pend_r <= 1'b1;
      rd_addr_r <= rq_addr_r;
    end else if (rd_pend_r) begin
      rd_pend_r <= 1'b0;
      rdata_r   <= REG_RD_DATA_I;
      rex_r     <= REG_EXISTS_I; // RL9
      ack_tgl_r <= ~ack_tgl_r;
    end
  end
  assign REG_ADDR_O = rd_addr_r;

  // ****************************************
  // Link domain: receive on falling sclk
  // ****************************************
  assign link_rst = SPI_CS_N_I | ~rst_ok_r; // RL1 RL2
  assign l_arst   = ~rst_ok_r;

  // Frame opener, set while idle
  always_ff @(negedge SPI_SCLK_I or posedge link_rst) begin
    if (link_rst) begin
      start_r <= 1'b1; // RL2
    end else begin
      start_r <= 1'b0;
    end
  end

  // Next count, saturating
  always_comb begin
    if (start_r) begin
      cnt_nxt = CNT_W'(1);
    end else if (&cnt_r) begin
      cnt_nxt = cnt_r;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end
  assign rx_word  = {sh_r[14:0], SPI_MOSI_I};
  assign word_end = (cnt_nxt >= CNT_W'(`IST_FRAME_BITS)) &&
                    (cnt_nxt[3:0] == 4'h0);

  // Shift in, decode address and instruction
  always_ff @(negedge SPI_SCLK_I or posedge l_arst) begin
    if (l_arst) begin
      cnt_r     <= '0;
      sh_r      <= '0;
      fr_tgl_r  <= 1'b0;
      match_r   <= 1'b0;
      instr_r   <= '0;
      ipar_ok_r <= 1'b0;
      dbad_r    <= 1'b0;
      rq_tgl_r  <= 1'b0;
      rq_addr_r <= '0;
    end else begin
      cnt_r <= cnt_nxt; // RL14
      sh_r  <= {sh_r[30:0], SPI_MOSI_I}; // RL3
      if (start_r) begin
        fr_tgl_r <= ~fr_tgl_r;
        match_r  <= 1'b0;
        dbad_r   <= 1'b0;
      end
      if (cnt_nxt == CNT_W'(`IST_CHIP_BITS)) begin
        match_r <= rx_word[1:0] ==
                   {`IST_CHIP_MSB, addr_lo_r}; // RL5 RL19
      end
      if (cnt_nxt == CNT_W'(`IST_ADDR_DONE)) begin
        rq_addr_r <= rx_word[7:0];
        rq_tgl_r  <= ~rq_tgl_r;
      end
      if (cnt_nxt == CNT_W'(`IST_WORD_BITS)) begin
        instr_r   <= rx_word;
        ipar_ok_r <= ^rx_word; // RL23
      end
      if (word_end && !(^rx_word)) begin
        dbad_r <= 1'b1; // RL8 RL11 RL23
      end
      // Burst: look up the next address early
      if ((cnt_nxt > CNT_W'(`IST_WORD_BITS)) &&
          (cnt_nxt[3:0] == 4'h1)) begin
        rq_addr_r <= rq_addr_r + 8'h01; // RL22
        rq_tgl_r  <= ~rq_tgl_r;
      end
    end
  end

  // Burst write posted per complete good word
  always_ff @(negedge SPI_SCLK_I or posedge l_arst) begin
    if (l_arst) begin
      pw_tgl_r  <= 1'b0;
      pw_addr_r <= '0;
      pw_data_r <= '0;
    end else if (word_end && match_r && !cm_bit && rw_bit &&
                 ipar_ok_r && (^rx_word) && ex_cur_r) begin
      pw_tgl_r  <= ~pw_tgl_r; // RL25 RL12
      pw_addr_r <= rq_addr_r - 8'h01;
      pw_data_r <= rx_word[14:0];
    end
  end

  // ****************************************
  // Link domain: transmit on rising sclk
  // ****************************************
  // Lookup-done toggle crossing
  always_ff @(posedge SPI_SCLK_I or posedge l_arst) begin
    if (l_arst) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
    end
  end
  assign ack_ok = ack_s2_r == rq_tgl_r; // RL18

  // First rise of a frame counts as edge zero
  assign k = start_r ? '0 : cnt_r; // RL21
  always_comb begin
    if (k < CNT_W'(`IST_CHIP_BITS)) begin
      ph = ist_pkg::PH_CHIP;
    end else if (k < CNT_W'(`IST_CHECK_END)) begin
      ph = ist_pkg::PH_CHECK;
    end else if (k < CNT_W'(`IST_WORD_BITS)) begin
      ph = ist_pkg::PH_ECHO;
    end else begin
      ph = ist_pkg::PH_DATA;
    end
  end
  assign load    = (ph == ist_pkg::PH_DATA) && (k[3:0] == 4'h0);
  assign chk     = {`IST_CHK_PAT, fail_r}; // RL26 RL15
  assign chk_idx = 3'(CNT_W'(`IST_CHECK_END - 1) - k);
  // Unused code answers all ones
  always_comb begin
    if (ack_ok && rex_r) begin
      rsp_word = {~(^rdata_r), rdata_r};
    end else begin
      rsp_word = `IST_UNUSED_WORD; // RL13
    end
  end

  // Per-frame address status
  always_ff @(posedge SPI_SCLK_I or posedge l_arst) begin
    if (l_arst) begin
      ex_cur_r   <= 1'b0;
      bad_addr_r <= 1'b0;
    end else if (k == '0) begin
      ex_cur_r   <= 1'b0;
      bad_addr_r <= 1'b0;
    end else if (load) begin
      ex_cur_r <= ack_ok && rex_r;
      if (!(ack_ok && rex_r)) begin
        bad_addr_r <= 1'b1; // RL9
      end
    end
  end

  // Output bit and enable per phase
  always_ff @(posedge SPI_SCLK_I or posedge link_rst) begin
    if (link_rst) begin
      miso_r  <= 1'b0; // RL1
      oe_r    <= 1'b0;
      tx_sh_r <= '0;
    end else begin
      case (ph)
        ist_pkg::PH_CHIP: begin
          miso_r <= 1'b0; // RL5
          oe_r   <= 1'b0;
        end
        ist_pkg::PH_CHECK: begin
          miso_r <= chk[chk_idx]; // RL7 RL26
          oe_r   <= match_r; // RL5
        end
        ist_pkg::PH_ECHO: begin
          miso_r <= sh_r[3]; // RL26
        end
        default: begin
          if (load) begin
            miso_r  <= rsp_word[15]; // RL22
            tx_sh_r <= rsp_word[14:0];
          end else begin
            miso_r  <= tx_sh_r[14]; // RL3
            tx_sh_r <= {tx_sh_r[13:0], 1'b0};
          end
        end
      endcase
    end
  end

  // Pin released unless own frame is running
  assign SPI_MISO_OE_O = oe_r & ~SPI_CS_N_I & rst_ok_r; // RL27
  assign SPI_MISO_O    = miso_r;
endmodule // ist_spi_target

/* File: bench/ist_spi_target_props.sv */
// Purpose: Port checker for ist_spi_target.
// Assumes: Bound to the top module; link checks on falling SCLK.
// Notes:   Helper counters track reset release and frame bits.
`timescale 1ns/1ps
module ist_spi_target_props (
  // Clocks, reset and link pins
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic SPI_SCLK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_MOSI_I,
  input wire logic SPI_MISO_O,
  input wire logic SPI_MISO_OE_O,
  // Strap and status
  input wire logic CTRL_CFG_I,
  input wire logic REG_WR_O,
  input wire logic TRANSFER_FAIL_O,
  input wire logic CHIP_ADDR_LSB_O
);
  logic [3:0] rel_r;  // Cycles since reset release
  logic [5:0] bit_r;  // Falling edges in this frame
  logic [1:0] hdr_r;  // Chip address bits
  logic       own;    // Frame is for this chip
  assign own = (hdr_r == {1'b1, CHIP_ADDR_LSB_O});
  // Count cycles after reset, saturating
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) rel_r <= 4'h0;
    else if (rel_r != 4'hf) rel_r <= rel_r + 4'h1;
  end
  // Count frame bits, keep the first two
  always_ff @(negedge SPI_SCLK_I or posedge SPI_CS_N_I) begin
    if (SPI_CS_N_I) bit_r <= 6'h0;
    else begin
      if (bit_r < 6'h2) hdr_r <= {hdr_r[0], SPI_MOSI_I};
      if (bit_r != 6'h3f) bit_r <= bit_r + 6'h1;
    end
  end
  AST_RST_HIZ: assert property (@(posedge SYS_CLK_I)
    !RESETN_I ##1 !RESETN_I |-> !SPI_MISO_OE_O && !REG_WR_O)
    else $error("output active in reset");
  AST_CS_HIZ: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESETN_I) SPI_CS_N_I |-> !SPI_MISO_OE_O)
    else $error("miso driven while deselected");
  AST_WR_ONE: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESETN_I) REG_WR_O |=> !REG_WR_O [*3])
    else $error("write strobe too long");
  AST_FLAG_AT_CS: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESETN_I)
    rel_r == 4'hf && $changed(TRANSFER_FAIL_O) |-> SPI_CS_N_I)
    else $error("flag changed inside frame");
  AST_STRAP_HOLD: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESETN_I) rel_r == 4'hf |-> $stable(CHIP_ADDR_LSB_O))
    else $error("chip address moved");
  AST_STRAP_TAKE: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESETN_I)
    rel_r == 4'h9 |-> CHIP_ADDR_LSB_O == $past(CTRL_CFG_I, 4))
    else $error("strap not latched");
  AST_ADDR_HIZ: assert property (@(negedge SPI_SCLK_I)
    disable iff (!RESETN_I) bit_r < 6'h2 |-> !SPI_MISO_OE_O)
    else $error("miso driven in address phase");
  AST_FAR_CHIP: assert property (@(negedge SPI_SCLK_I)
    disable iff (!RESETN_I) bit_r >= 6'h2 && !own |-> !SPI_MISO_OE_O)
    else $error("miso driven for other chip");
  AST_OWN_DRIVE: assert property (@(negedge SPI_SCLK_I)
    disable iff (!RESETN_I || SPI_CS_N_I)
    bit_r >= 6'h2 && own |-> SPI_MISO_OE_O)
    else $error("miso not driven");
  AST_CHECK_PAT: assert property (@(negedge SPI_SCLK_I)
    disable iff (!RESETN_I) bit_r inside {[2:6]} && own
    |-> SPI_MISO_O == !bit_r[0])
    else $error("check pattern wrong");
  AST_FLAG_OUT: assert property (@(negedge SPI_SCLK_I)
    disable iff (!RESETN_I) bit_r == 6'h7 && own
    |-> SPI_MISO_O == TRANSFER_FAIL_O)
    else $error("flag bit wrong");
endmodule // ist_spi_target_props
bind ist_spi_target ist_spi_target_props chk_u (.SYS_CLK_I, .RESETN_I,
  .SPI_SCLK_I, .SPI_CS_N_I, .SPI_MOSI_I, .SPI_MISO_O, .SPI_MISO_OE_O,
  .CTRL_CFG_I, .REG_WR_O, .TRANSFER_FAIL_O, .CHIP_ADDR_LSB_O);

/* File: bench/ist_spi_master.sv */
// Purpose: Serial master model for the target's link pins.
// Assumes: SCLK idles low and stops between frames.
// Notes:   MOSI shows the inverse of its last bit when idle.
`timescale 1ns/1ps
module ist_spi_master (
  // Link pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  localparam int HALF_NS = 50;  // 10 MHz serial clock
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Drive chip select directly
  task automatic sel(input logic v);
    cs_n_o = v;
  endtask
  // One frame of n clocks, MSB first
  task automatic xfer(input logic [47:0] tx, input int n,
                      output logic [47:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    #(HALF_NS);
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b1;
      mosi_o = tx[47-i];
      #(HALF_NS);
      sclk_o = 1'b0;
      rx[47-i] = miso_i;
      #(HALF_NS);
    end
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #200;
  endtask
endmodule // ist_spi_master

/* File: bench/tb_ist_spi_target.sv */
// Purpose: Self-checking bench for ist_spi_target.
// Assumes: Register file model answers lookups at once.
// Notes:   Addresses 8'h00..8'h7f exist.
`timescale 1ns/1ps
module tb_ist_spi_target;
  logic sys_clk = 1'b0, rst_n = 1'b0, cfg = 1'b1, efail = 1'b0;
  logic sclk, cs_n, mosi, miso, oe, wr, fail, lsb;
  ist_pkg::ist_addr_t ra, wa;
  logic [14:0] wd, mem [256], emem [256];
  logic [31:0] lf = 32'hba896b77;
  int n_mismatch = 0, samples_checked = 0;
  wire logic miso_w = oe ? miso : 1'bz;  // Released line floats
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wr) mem[wa] <= wd;
  ist_spi_master master_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso_w));
  ist_spi_target dut_u (.SYS_CLK_I(sys_clk), .RESETN_I(rst_n),
    .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n), .SPI_MOSI_I(mosi),
    .SPI_MISO_O(miso), .SPI_MISO_OE_O(oe), .CTRL_CFG_I(cfg),
    .REG_ADDR_O(ra), .REG_RD_DATA_I(mem[ra]), .REG_EXISTS_I(!ra[7]),
    .REG_WR_O(wr), .REG_WADDR_O(wa), .REG_WDATA_O(wd),
    .TRANSFER_FAIL_O(fail), .CHIP_ADDR_LSB_O(lsb));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected answer word for a read
  function automatic logic [15:0] resp(input logic [7:0] a);
    return a[7] ? 16'hffff : {~^emem[a], emem[a]};
  endfunction
  task automatic chk(input logic [47:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset with chip select low, strap v
  task automatic rst(input logic v);
    @(posedge sys_clk) #1;
    rst_n = 1'b0;
    cfg = v;
    master_u.sel(1'b0);
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(lsb, v);
    #1 master_u.sel(1'b1);
    efail = 1'b1;
    #200;
    chk(fail, efail);
  endtask
  // One frame: chip, rw, length check, address, clocks, bad parity
  task automatic frame(input logic c, rw, mon, input logic [7:0] a,
                       input int n, input logic bp);
    logic [15:0] w;
    logic [14:0] d;
    logic [47:0] rx, ex;
    logic own, inv;
    lf = nxt(lf);
    d = lf[14:0];
    w = {1'b1, c, rw, mon, a, 4'h0};
    w[0] = ~^w[15:1];
    own = (c === cfg);
    ex = {2'bzz, 5'h15, efail, a, resp(a), resp(a + 8'h1)};
    if (!own) ex = 'z;
    master_u.xfer({w, ~^d ^ bp, d, ^d, ~d}, n, rx);
    for (int i = n; i < 48; i++) ex[47-i] = rx[47-i];
    chk(rx, ex);
    inv = a[7] | bp | (mon ? n != 32 : n % 16 != 0);
    if (own) efail = inv;
    if (own && !inv && rw) emem[a] = d;
    if (own && !inv && rw && !mon) emem[a + 8'h1] = ~d;
    chk(fail, efail);
    chk(mem[a], emem[a]);
    chk(mem[a + 8'h1], emem[a + 8'h1]);
  endtask
  initial begin
    #300000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    logic [7:0] a;
    for (int i = 0; i < 256; i++) begin
      mem[i] = '0;
      emem[i] = '0;
    end
    for (int s = 1; s >= 0; s--) begin
      rst(s[0]);
      repeat (3) begin
        lf = nxt(lf);
        a = {2'b00, lf[5:0]};
        frame(s[0], 1'b1, 1'b1, a, 32, 1'b0);
        frame(s[0], 1'b0, 1'b1, a, 32, 1'b0);
      end
      frame(s[0], 1'b1, 1'b1, a, 32, 1'b1);
      frame(s[0], 1'b0, 1'b1, a, 32, 1'b1);
      frame(s[0], 1'b1, 1'b1, a, 31, 1'b0);
      frame(s[0], 1'b0, 1'b1, a, 32, 1'b0);
      frame(s[0], 1'b0, 1'b1, 8'h90, 32, 1'b0);
      frame(!s[0], 1'b1, 1'b1, a, 32, 1'b0);
      frame(s[0], 1'b1, 1'b0, a, 48, 1'b0);
      frame(s[0], 1'b0, 1'b0, a, 48, 1'b0);
    end
    stop_test;
  end
endmodule // tb_ist_spi_target
